//--- host_bus_pkg.sv
// Constants and types for the multiplexed host bus port
`default_nettype none
package host_bus_pkg;
   localparam int unsigned PIN_W = 22;
   localparam logic [2:0] WORDS_PER_DW = 3'h2;
   localparam logic [2:0] BYTES_PER_DW = 3'h4;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [31:0] DW_RST = 32'h0000_0000;
   localparam logic [3:0] BE_RST = 4'h0;
   localparam logic [2:0] CNT_RST = 3'h0;

   typedef struct packed {
      logic endian;
      logic [15:0] ad;
      logic hi;
      logic lo;
      logic cs;
      logic rd;
      logic wr;
   } pins_t;

   typedef struct packed {
      logic endian;
      logic [15:0] addr;
   } addr_t;

   typedef struct packed {
      logic valid;
      logic [3:0] be;
      logic [31:0] data;
   } wr_req_t;

   function automatic logic [31:0] swap32(input logic [31:0] d);
      swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction
endpackage
`default_nettype wire

//--- muxed_host_bus_port.sv
// Device end of the multiplexed address/data host bus port
`timescale 1ns/100ps
`default_nettype none
module muxed_host_bus_port #(
   parameter int unsigned SYNC_STAGES = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Straps
   input wire logic latch_polarity_cfg,
   input wire logic select_polarity_cfg,
   input wire logic read_dir_polarity_cfg,
   input wire logic write_enable_polarity_cfg,
   input wire logic strobe_style_cfg,
   input wire logic latch_gating_cfg,
   input wire logic dual_phase_cfg,
   input wire logic wide_data_cfg,
   // Host pins
   input wire logic high_addr_latch_strobe,
   input wire logic low_addr_latch_strobe,
   input wire logic chip_select,
   input wire logic read_strobe,
   input wire logic write_strobe,
   input wire logic endian_sel,
   input wire logic [15:0] ad_in,
   output logic [15:0] ad_out,
   output logic ad_oe_lo,
   output logic ad_oe_hi,
   // Register side
   input wire logic partial_ok,
   input wire logic [31:0] reg_rd_data,
   output host_bus_pkg::addr_t reg_addr,
   output logic reg_rd_hold,
   output logic reg_rd_done,
   output host_bus_pkg::wr_req_t reg_wr
);
   if (SYNC_STAGES < 2) begin : g_chk
      $error("SYNC_STAGES must be at least 2");
   end

   // Synchroniser chain
   host_bus_pkg::pins_t pin_raw;
   logic [host_bus_pkg::PIN_W-1:0] sync_r [SYNC_STAGES];
   host_bus_pkg::pins_t cur;
   host_bus_pkg::pins_t pin_idle;
   // Inactive pin levels for the chain's reset
   assign pin_idle = '{endian: 1'b0, ad: host_bus_pkg::ADDR_RST, hi: ~latch_polarity_cfg,
                       lo: ~latch_polarity_cfg, cs: ~select_polarity_cfg, rd: ~read_dir_polarity_cfg,
                       wr: ~write_enable_polarity_cfg};
   assign pin_raw = '{endian: endian_sel, ad: ad_in, hi: high_addr_latch_strobe,
                      lo: low_addr_latch_strobe, cs: chip_select, rd: read_strobe, wr: write_strobe};
   assign cur = host_bus_pkg::pins_t'(sync_r[SYNC_STAGES-1]);

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            sync_r[i] <= pin_idle;
         end
      end else begin
         sync_r[0] <= pin_raw;
         for (int i = 1; i < SYNC_STAGES; i++) begin
            sync_r[i] <= sync_r[i-1];
         end
      end
   end

   // Polarity and strobe style decode
   wire hi_a = cur.hi ~^ latch_polarity_cfg;
   wire lo_a = cur.lo ~^ latch_polarity_cfg;
   wire cs_a = cur.cs ~^ select_polarity_cfg;
   wire rd_pin_a = cur.rd ~^ read_dir_polarity_cfg;
   wire wr_pin_a = cur.wr ~^ write_enable_polarity_cfg;
   wire rd_a = strobe_style_cfg ? (wr_pin_a & rd_pin_a) : rd_pin_a;
   wire wr_a = strobe_style_cfg ? (wr_pin_a & ~rd_pin_a) : wr_pin_a;
   wire rd_cyc = cs_a & rd_a;
   wire wr_cyc = cs_a & wr_a;
   wire latch_ok = ~latch_gating_cfg | cs_a;
   wire hi_ld = dual_phase_cfg & hi_a & latch_ok;
   wire lo_ld = lo_a & latch_ok;

   // Cycle edges
   logic rd_cyc_r;
   logic wr_cyc_r;
   wire rd_start = rd_cyc & ~rd_cyc_r;
   wire rd_end = ~rd_cyc & rd_cyc_r;
   wire wr_end = ~wr_cyc & wr_cyc_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         rd_cyc_r <= 1'b0;
         wr_cyc_r <= 1'b0;
      end else begin
         rd_cyc_r <= rd_cyc;
         wr_cyc_r <= wr_cyc;
      end
   end

   // Address latch
   host_bus_pkg::addr_t addr_r;
   host_bus_pkg::addr_t addr_nxt;
   always_comb begin
      addr_nxt = addr_r;
      if (dual_phase_cfg) begin
         if (lo_ld) begin
            addr_nxt.addr[7:0] = cur.ad[7:0];
         end
         if (hi_ld) begin
            addr_nxt.addr[15:8] = cur.ad[7:0];
         end
      end else if (lo_ld) begin
         addr_nxt.addr = cur.ad;
      end
      if (hi_ld | lo_ld) begin
         addr_nxt.endian = cur.endian;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         addr_r <= '{endian: 1'b0, addr: host_bus_pkg::ADDR_RST};
      end else begin
         addr_r <= addr_nxt;
      end
   end
   assign reg_addr = addr_r;

   // Lane selection
   wire [2:0] dw_parts = wide_data_cfg ? host_bus_pkg::WORDS_PER_DW : host_bus_pkg::BYTES_PER_DW;
   wire [2:0] cnt_last = dw_parts - 3'h1;
   wire [4:0] sh = wide_data_cfg ? {addr_r.addr[1], 4'h0} : {addr_r.addr[1:0], 3'h0};
   wire [31:0] lane_m = wide_data_cfg ? (32'h0000_ffff << sh) : (32'h0000_00ff << sh);
   wire [3:0] lane_be = wide_data_cfg ? (4'h3 << {addr_r.addr[1], 1'b0}) : (4'h1 << addr_r.addr[1:0]);

   // Read path
   logic [31:0] snap_r;
   logic [2:0] rd_cnt_r;
   logic [15:0] ad_out_r;
   logic oe_r;
   logic rd_done_r;
   wire [31:0] rd_src = (partial_ok | (rd_cnt_r == host_bus_pkg::CNT_RST)) ? reg_rd_data : snap_r;
   wire [31:0] rd_view = addr_r.endian ? host_bus_pkg::swap32(rd_src) : rd_src;
   wire [31:0] rd_sh = rd_view >> sh;
   wire rd_last = partial_ok | (rd_cnt_r == cnt_last);
   assign reg_rd_hold = rd_start & (rd_cnt_r == host_bus_pkg::CNT_RST);

   always_ff @(posedge clk) begin
      if (reset) begin
         snap_r <= host_bus_pkg::DW_RST;
         rd_cnt_r <= host_bus_pkg::CNT_RST;
         ad_out_r <= host_bus_pkg::ADDR_RST;
         oe_r <= 1'b0;
         rd_done_r <= 1'b0;
      end else begin
         oe_r <= rd_cyc;
         rd_done_r <= rd_end & rd_last;
         if (reg_rd_hold) begin
            snap_r <= reg_rd_data;
         end
         if (rd_start) begin
            ad_out_r <= wide_data_cfg ? rd_sh[15:0] : {8'h00, rd_sh[7:0]};
         end
         if (rd_end) begin
            rd_cnt_r <= rd_last ? host_bus_pkg::CNT_RST : rd_cnt_r + 3'h1;
         end
      end
   end
   assign ad_out = ad_out_r;
   assign ad_oe_lo = oe_r;
   assign ad_oe_hi = oe_r & wide_data_cfg;
   assign reg_rd_done = rd_done_r;

   // Write path
   logic [15:0] wdat_r;
   logic [31:0] asm_r;
   logic [3:0] be_r;
   logic [2:0] wr_cnt_r;
   host_bus_pkg::wr_req_t wr_r;
   wire [31:0] wdat_sh = {16'h0000, wdat_r} << sh;
   wire [31:0] asm_nxt = (asm_r & ~lane_m) | (wdat_sh & lane_m);
   wire [3:0] be_nxt = be_r | lane_be;
   wire [3:0] be_sw = {be_nxt[0], be_nxt[1], be_nxt[2], be_nxt[3]};
   wire wr_last = partial_ok | (wr_cnt_r == cnt_last);

   always_ff @(posedge clk) begin
      if (reset) begin
         wdat_r <= host_bus_pkg::ADDR_RST;
         asm_r <= host_bus_pkg::DW_RST;
         be_r <= host_bus_pkg::BE_RST;
         wr_cnt_r <= host_bus_pkg::CNT_RST;
         wr_r <= '{valid: 1'b0, be: host_bus_pkg::BE_RST, data: host_bus_pkg::DW_RST};
      end else begin
         wr_r.valid <= 1'b0;
         if (wr_cyc) begin
            wdat_r <= wide_data_cfg ? cur.ad : {8'h00, cur.ad[7:0]};
         end
         if (wr_end) begin
            if (wr_last) begin
               wr_r.valid <= 1'b1;
               wr_r.data <= addr_r.endian ? host_bus_pkg::swap32(asm_nxt) : asm_nxt;
               wr_r.be <= addr_r.endian ? be_sw : be_nxt;
               be_r <= host_bus_pkg::BE_RST;
               wr_cnt_r <= host_bus_pkg::CNT_RST;
            end else begin
               be_r <= be_nxt;
               wr_cnt_r <= wr_cnt_r + 3'h1;
            end
            asm_r <= asm_nxt;
         end
      end
   end
   assign reg_wr = wr_r;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_read_begin;
      rd_start;
   endsequence
   sequence s_last_write;
      wr_end && !partial_ok && (wr_cnt_r == cnt_last);
   endsequence

   property p_drive_read;
      s_read_begin |=> ad_oe_lo && (ad_out == $past(wide_data_cfg ? rd_sh[15:0] : {8'h00, rd_sh[7:0]}));
   endproperty
   a_drive_read: assert property (p_drive_read) else $error("read data not driven");
   property p_release;
      $fell(rd_cyc) |=> !ad_oe_lo && !ad_oe_hi;
   endproperty
   a_release: assert property (p_release) else $error("pins held after read");
   property p_hi_quiet;
      !wide_data_cfg |-> !ad_oe_hi;
   endproperty
   a_hi_quiet: assert property (p_hi_quiet) else $error("upper lane driven in 8-bit");
   property p_commit;
      s_last_write |=> reg_wr.valid ##1 !reg_wr.valid;
   endproperty
   a_commit: assert property (p_commit) else $error("DWORD write missing");
   property p_no_early;
      wr_end && !wr_last |=> !reg_wr.valid;
   endproperty
   a_no_early: assert property (p_no_early) else $error("early DWORD write");
   property p_hold_addr;
      !hi_ld && !lo_ld |=> $stable(reg_addr);
   endproperty
   a_hold_addr: assert property (p_hold_addr) else $error("address changed without latch");
   property p_single;
      lo_ld && !dual_phase_cfg |=> reg_addr.addr == $past(cur.ad);
   endproperty
   a_single: assert property (p_single) else $error("single phase address wrong");
   property p_dual_hi;
      hi_ld && !lo_ld |=> (reg_addr.addr[15:8] == $past(cur.ad[7:0])) && $stable(reg_addr.addr[7:0]);
   endproperty
   a_dual_hi: assert property (p_dual_hi) else $error("high address phase wrong");
   property p_rd_done;
      rd_end && !partial_ok && (rd_cnt_r == cnt_last) |=> reg_rd_done ##1 !reg_rd_done;
   endproperty
   a_rd_done: assert property (p_rd_done) else $error("read completion missing");
   property p_endian;
      hi_ld || lo_ld |=> reg_addr.endian == $past(cur.endian);
   endproperty
   a_endian: assert property (p_endian) else $error("endian not captured");
   property p_lo_dual;
      lo_ld && !hi_ld && dual_phase_cfg |=> (reg_addr.addr[7:0] == $past(cur.ad[7:0])) && $stable(reg_addr.addr[15:8]);
   endproperty
   a_lo_dual: assert property (p_lo_dual) else $error("low address phase wrong");
   property p_gated;
      latch_gating_cfg && !cs_a |=> $stable(reg_addr);
   endproperty
   a_gated: assert property (p_gated) else $error("latch taken without select");
   property p_single_keep;
      !dual_phase_cfg && !lo_ld |=> $stable(reg_addr);
   endproperty
   a_single_keep: assert property (p_single_keep) else $error("single phase address lost");
   property p_one_commit;
      reg_wr.valid |=> !reg_wr.valid;
   endproperty
   a_one_commit: assert property (p_one_commit) else $error("write pulse too long");
   property p_wide_lanes;
      ad_oe_lo && wide_data_cfg |-> ad_oe_hi;
   endproperty
   a_wide_lanes: assert property (p_wide_lanes) else $error("upper lane missing in 16-bit");
   property p_idle_off;
      !rd_cyc |=> !ad_oe_lo && !ad_oe_hi;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("pins driven outside read");
   property p_part_wr;
      wr_end && partial_ok |=> reg_wr.valid;
   endproperty
   a_part_wr: assert property (p_part_wr) else $error("partial write not committed");
   property p_part_rd;
      rd_end && partial_ok |=> reg_rd_done;
   endproperty
   a_part_rd: assert property (p_part_rd) else $error("partial read not completed");
   property p_cnt_range;
      (wr_cnt_r < dw_parts) && (rd_cnt_r < dw_parts);
   endproperty
   a_cnt_range: assert property (p_cnt_range) else $error("part counter out of range");
endmodule
`default_nettype wire

//--- host_model.sv
// Host controller model for the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module host_model (
   // Clock and straps
   input wire logic clk,
   input wire logic [7:0] cfg,
   // Bus
   input wire logic [15:0] bus,
   output wire host_bus_pkg::pins_t p
);
   logic hi_a = 1'h0, lo_a = 1'h0, cs_a = 1'h0, rd_a = 1'h0, wr_a = 1'h0;
   logic en_a = 1'h0, dir = 1'h0, drv = 1'h0, endian = 1'h0;
   logic [15:0] val = 16'h0000, last = 16'h0000;
   assign p.endian = endian;
   assign p.ad = drv ? val : ~last;
   assign p.hi = cfg[7] ~^ hi_a;
   assign p.lo = cfg[7] ~^ lo_a;
   assign p.cs = cfg[6] ~^ cs_a;
   assign p.rd = cfg[5] ~^ (cfg[3] ? dir : rd_a);
   assign p.wr = cfg[4] ~^ (cfg[3] ? en_a : wr_a);
   task automatic latch(input logic hi, input logic [15:0] a, input logic e, input logic cs);
      @(negedge clk);
      val = a;
      drv = 1'h1;
      endian = e;
      cs_a = cs;
      hi_a = hi;
      lo_a = !hi;
      repeat (4) @(negedge clk);
      hi_a = 1'h0;
      lo_a = 1'h0;
      repeat (3) @(negedge clk);
      drv = 1'h0;
      last = a;
      cs_a = 1'h0;
      repeat (3) @(negedge clk);
   endtask
   task automatic xfer(input logic rd, input logic [15:0] d, output logic [15:0] q);
      @(negedge clk);
      dir = rd;
      val = d;
      drv = !rd;
      @(negedge clk);
      cs_a = 1'h1;
      rd_a = rd;
      wr_a = !rd;
      en_a = 1'h1;
      repeat (5) @(negedge clk);
      q = bus;
      rd_a = 1'h0;
      wr_a = 1'h0;
      en_a = 1'h0;
      cs_a = 1'h0;
      repeat (3) @(negedge clk);
      drv = 1'h0;
      last = rd ? last : d;
      repeat (2) @(negedge clk);
   endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the multiplexed host bus port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk = 1'h0, reset = 1'h1, pok = 1'h0;
   logic [7:0] cfg = 8'hf7;
   logic [31:0] rdata = 32'h0000_0000, wd;
   logic [15:0] q, ad_out;
   logic oe_lo, oe_hi, rd_done;
   wire [15:0] bus;
   wire host_bus_pkg::pins_t p;
   host_bus_pkg::addr_t ra;
   host_bus_pkg::wr_req_t wr, wr_last;
   int err_total = 0, total_checks = 0, wr_n = 0, rd_n = 0, hi_bad = 0, cyc = 0, nw = 0;
   int ord[$];
   initial begin
      forever #2 clk = ~clk;
   end
   assign bus = {oe_hi ? ad_out[15:8] : p.ad[15:8], oe_lo ? ad_out[7:0] : p.ad[7:0]};
   host_model h (.clk(clk), .cfg(cfg), .bus(bus), .p(p));
   muxed_host_bus_port u_dut (.clk(clk), .reset(reset), .latch_polarity_cfg(cfg[7]),
      .select_polarity_cfg(cfg[6]), .read_dir_polarity_cfg(cfg[5]), .write_enable_polarity_cfg(cfg[4]),
      .strobe_style_cfg(cfg[3]), .latch_gating_cfg(cfg[2]), .dual_phase_cfg(cfg[1]), .wide_data_cfg(cfg[0]),
      .high_addr_latch_strobe(p.hi), .low_addr_latch_strobe(p.lo), .chip_select(p.cs), .read_strobe(p.rd),
      .write_strobe(p.wr), .endian_sel(p.endian), .ad_in(bus), .ad_out(ad_out), .ad_oe_lo(oe_lo),
      .ad_oe_hi(oe_hi), .partial_ok(pok), .reg_rd_data(rdata), .reg_addr(ra), .reg_rd_hold(),
      .reg_rd_done(rd_done), .reg_wr(wr));
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wr.valid === 1'h1) begin
         wr_n <= wr_n + 1;
         wr_last <= wr;
      end
      if (rd_done === 1'h1) rd_n <= rd_n + 1;
      if (oe_hi === 1'h1 && cfg[0] === 1'h0) hi_bad <= hi_bad + 1;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end
   function automatic logic [31:0] rev(input logic [31:0] d);
      return {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd_chk(input logic e, input logic [1:0] a);
      logic [31:0] x;
      x = e ? rev(rdata) : rdata;
      h.xfer(1'h1, 16'h0000, q);
      if (cfg[0]) chk("word", 32'(q), 32'(x[16 * a[1] +: 16]));
      else chk("byte", 32'(q[7:0]), 32'(x[8 * a +: 8]));
   endtask
   task automatic mode(input logic [7:0] c);
      @(negedge clk);
      cfg = c;
      reset = 1'h1;
      repeat (2) @(negedge clk);
      reset = 1'h0;
      repeat (5) @(negedge clk);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(89));
      mode(8'hf7);
      for (int e = 0; e < 2; e++) begin
         rdata = $urandom;
         wd = $urandom;
         h.latch(e[0], {8'($urandom), e[0] ? 8'h12 : 8'h36}, e[0], 1'h1);
         h.latch(!e[0], {8'($urandom), e[0] ? 8'h36 : 8'h12}, e[0], 1'h1);
         chk("addr", 32'(ra), {15'h0000, e[0], 16'h1236});
         rd_chk(e[0], 2'h2);
         h.xfer(1'h0, wd[31:16], q);
         chk("early commit", 32'(wr_n), 32'(nw));
         h.latch(1'h0, {8'($urandom), 8'h34}, e[0], 1'h1);
         chk("addr", 32'(ra), {15'h0000, e[0], 16'h1234});
         rd_chk(e[0], 2'h0);
         chk("read done", 32'(rd_n), 32'(e + 1));
         h.xfer(1'h0, wd[15:0], q);
         nw++;
         chk("commit", 32'(wr_n), 32'(nw));
         chk("wdata", wr_last.data, e ? rev(wd) : wd);
      end
      h.latch(1'h0, 16'h0078, 1'h0, 1'h0);
      chk("gated", 32'(ra), 32'h0001_1234);
      mode(8'hf3);
      h.latch(1'h0, 16'h0078, 1'h0, 1'h0);
      chk("ungated", 32'(ra), 32'h0000_0078);
      mode(8'h08);
      rdata = $urandom;
      wd = $urandom;
      ord = '{3, 1, 0, 2};
      foreach (ord[i]) begin
         h.latch(1'h0, {8'hab, 6'h0d, 2'(ord[i])}, 1'h1, 1'h1);
         chk("addr", 32'(ra), {15'h0000, 1'h1, 8'hab, 6'h0d, 2'(ord[i])});
         rd_chk(1'h1, 2'(ord[i]));
      end
      foreach (ord[i]) begin
         h.latch(1'h0, {8'hab, 6'h0d, 2'(ord[(i + 2) % 4])}, 1'h1, 1'h1);
         h.xfer(1'h0, {8'($urandom), wd[8 * ord[(i + 2) % 4] +: 8]}, q);
      end
      nw++;
      chk("commit", 32'(wr_n), 32'(nw));
      chk("bdata", wr_last.data, rev(wd));
      chk("be", 32'(wr_last.be), 32'h0000_000f);
      chk("upper lane", 32'(hi_bad), 32'h0000_0000);
      pok = 1'h1;
      for (int k = 0; k < 2; k++) begin
         h.xfer(1'h0, 16'($urandom), q);
         chk("partial", 32'(wr_n), 32'(nw + k + 1));
         chk("pbe", 32'(wr_last.be), 32'h0000_0004);
         rd_chk(1'h1, 2'h1);
         chk("partial read", 32'(rd_n), 32'(k + 4));
      end
      end_sim();
   end
endmodule
`default_nettype wire
